// *** hw/mtp_pkg.sv ***
// Purpose: shared constants and types for the message text priority display block
// Assumes: 25 MHz single clock, AXI4-Lite register access
// Notes:   config word layout is shared by the register map and the selection logic
package mtp_pkg;
  localparam int          NB        = 50;
  localparam int          IDX_W     = 6;
  localparam int          PRIO_W    = 7;
  localparam int          STAMP_W   = 16;
  localparam int          CFG_W     = 19;
  localparam int          CLK_MHZ   = 25;
  localparam int          TICK_UNIT_US = 1000;
  localparam int          LL_MULT   = 10;
  localparam logic [15:0] TICK_MS_RST = 16'h0064;
  // config word fields
  localparam int          CFG_PRIO_LSB = 0;
  localparam int          CFG_ACK      = 7;
  localparam int          CFG_TTYPE    = 8;
  localparam int          CFG_DST_LSB  = 9;
  localparam int          CFG_WEB      = 11;
  localparam int          CFG_LINE_LSB = 12;
  localparam int          CFG_CSET     = 18;
  localparam logic [CFG_W-1:0] CFG_RST = 19'h00200;
  // destination codes
  localparam logic [1:0]  DST_ONB   = 2'h1;
  localparam logic [1:0]  DST_PANEL = 2'h2;
  localparam logic [1:0]  DST_BOTH  = 2'h3;
  // register map, byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_ACT_LO = 12'h008;
  localparam logic [11:0] ADDR_ACT_HI = 12'h00C;
  localparam logic [11:0] ADDR_CFG0   = 12'h100;
  localparam int          CTRL_CSUSE  = 0;
  localparam int          CTRL_TICK_LSB = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// *** hw/mtp_key_edge.sv ***
// Purpose: synchronise operator key pins and turn presses into one-cycle pulses
// Assumes: keys are asynchronous, active high, already debounced
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module mtp_key_edge
  import mtp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // raw keys and pulses
  input  wire logic [2:0] key_i,
  output logic      [2:0] press_o
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
  } mtp_key_s;

  mtp_key_s q;
  mtp_key_s d;

  always_comb
  begin
    d    = q;
    d.s1 = key_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q <= '0;
    else
      q <= d;
  end

  assign press_o = q.s2 & ~q.s3;
endmodule // mtp_key_edge

// *** hw/mtp_display.sv ***
// Purpose: fifty message blocks, priority pick, acknowledge, stepping and ticking
// Assumes: enables, run state and charset flag come from program logic on ref_clk_i
// Notes:   registers over AXI4-Lite; keys pass a two-flop synchroniser
// What this block does
// - message starts on enable rising edge
// - priority limited to 0 through 127
// - tick type: per character or line half
// - destination onboard, external panel, or both
// - six line enables; only enabled lines scroll
// - status high while message is active
// - at most fifty message blocks
// - present messages only in run state
// - charset flag picks set one or two
// - no ack mode: falling enable removes message
// - ack mode: message stays until OK pressed
// - OK ignored while enable is high
// - highest priority active message is shown
// - newcomer shown only if strictly highest
// - on removal show highest remaining message
// - up and down keys step active messages
// - scroll displayed message by tick type
// - per-block web visibility setting
// - line-half interval is ten tick times
`timescale 1ns/1ps
module mtp_display
  import mtp_pkg::*;
#(
  parameter int MS_CYCLES = TICK_UNIT_US * CLK_MHZ
)
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  // program logic side
  input  wire logic [NB-1:0]     en_i,
  input  wire logic              run_i,
  input  wire logic              charset_select_flag_i,
  output logic      [NB-1:0]     status_o,
  // operator keys: ok, up, down
  input  wire logic              key_ok_i,
  input  wire logic              key_up_i,
  input  wire logic              key_down_i,
  // display side
  output logic                   disp_valid_o,
  output logic      [IDX_W-1:0]  disp_idx_o,
  output logic                   onboard_screen_o,
  output logic                   external_text_panel_o,
  output logic                   web_show_o,
  output logic      [5:0]        line_scroll_enable_o,
  output logic      [7:0]        scroll_pos_o,
  output logic                   line_half_o,
  // axi4-lite slave
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [11:0]       s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp
);
  typedef struct packed {
    logic [NB-1:0][CFG_W-1:0]   cfg;
    logic [NB-1:0][STAMP_W-1:0] stamp;
    logic [STAMP_W-1:0]         seq;
    logic [NB-1:0]              en_prev;
    logic [NB-1:0]              active;
    logic [IDX_W-1:0]           disp;
    logic                       disp_v;
    logic                       cs_use;
    logic [15:0]                tick_ms;
    logic [14:0]                ms_cnt;
    logic [19:0]                tick_cnt;
    logic [7:0]                 pos;
    logic                       half;
    logic                       onb;
    logic                       pan;
    logic                       web;
    logic [5:0]                 lines;
    logic                       aw_v;
    logic [11:0]                aw_a;
    logic                       w_v;
    logic [31:0]                w_d;
    logic [3:0]                 w_s;
    logic                       awrdy;
    logic                       wrdy;
    logic                       arrdy;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } mtp_state_s;

  mtp_state_s q;
  mtp_state_s d;
  logic [2:0] press;

  mtp_key_edge u_keys (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .key_i     ({key_down_i, key_up_i, key_ok_i}),
    .press_o   (press)
  );

  // a beats b: higher priority, or equal priority and activated earlier
  function automatic logic beats(input logic [PRIO_W-1:0] pa, input logic [STAMP_W-1:0] sa,
                                 input logic [PRIO_W-1:0] pb, input logic [STAMP_W-1:0] sb);
    beats = (pa > pb) || ((pa == pb) && (sa < sb));
  endfunction

  function automatic logic [PRIO_W-1:0] prio_of(input logic [CFG_W-1:0] c);
    prio_of = c[CFG_PRIO_LSB +: PRIO_W];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        merge[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction

  logic [NB-1:0]      rise;
  logic [NB-1:0]      newly;
  logic [NB-1:0]      elig;
  logic [IDX_W-1:0]   best;
  logic               best_v;
  logic [IDX_W-1:0]   step;
  logic               step_v;
  logic [IDX_W-1:0]   cand;
  logic [19:0]        limit;
  logic [31:0]        wword;
  logic [11:0]        widx;
  logic [11:0]        ridx;
  logic [CFG_W-1:0]   dc;

  always_comb
  begin
    d      = q;
    rise   = '0;
    newly  = '0;
    elig   = '0;
    best   = '0;
    best_v = 1'b0;
    step   = '0;
    step_v = 1'b0;
    cand   = '0;
    limit  = '0;
    wword  = '0;
    widx   = '0;
    ridx   = '0;
    dc     = '0;

    // millisecond base enable
    if (q.ms_cnt == 15'(MS_CYCLES - 1))
      d.ms_cnt = '0;
    else
      d.ms_cnt = q.ms_cnt + 15'h0001;

    // activation and removal per block
    d.en_prev = en_i;
    for (int i = 0; i < NB; i++)
    begin
      rise[i] = en_i[i] & ~q.en_prev[i];
      if (!run_i)
        d.active[i] = 1'b0;
      else if (rise[i] && !q.active[i])
      begin
        d.active[i] = 1'b1;
        d.stamp[i]  = q.seq;
        newly[i]    = 1'b1;
      end
      else if (!en_i[i] && q.en_prev[i] && !q.cfg[i][CFG_ACK])
        d.active[i] = 1'b0;
      else if (press[0] && !en_i[i] && q.cfg[i][CFG_ACK] && q.disp_v
               && q.disp == IDX_W'(i))
        d.active[i] = 1'b0;
    end
    if (|newly)
      d.seq = q.seq + 16'h0001;

    // charset filter
    for (int i = 0; i < NB; i++)
    begin
      elig[i] = d.active[i] &
                (~q.cs_use | (q.cfg[i][CFG_CSET] == charset_select_flag_i));
    end

    // highest priority pick, ties to the earliest stamp
    for (int i = 0; i < NB; i++)
    begin
      if (elig[i] && (!best_v || beats(prio_of(q.cfg[i]), d.stamp[i],
                                       prio_of(q.cfg[best]), d.stamp[best])))
      begin
        best   = IDX_W'(i);
        best_v = 1'b1;
      end
    end

    // up steps to higher index, down to lower, both wrap
    for (int k = 1; k < NB; k++)
    begin
      if (press[1])
        cand = IDX_W'((32'(q.disp) + k) % NB);
      else
        cand = IDX_W'((32'(q.disp) + NB - k) % NB);
      if (!step_v && elig[cand])
      begin
        step   = cand;
        step_v = 1'b1;
      end
    end

    if (!q.disp_v || !elig[q.disp])
    begin
      d.disp   = best;
      d.disp_v = best_v;
    end
    else if (best_v && newly[best])
      d.disp = best;
    else if ((press[1] ^ press[2]) && step_v)
      d.disp = step;

    // scrolling of the shown message
    dc = q.cfg[d.disp];
    limit = dc[CFG_TTYPE] ? 20'(32'(q.tick_ms) * LL_MULT) : 20'(q.tick_ms);
    if (d.disp != q.disp || d.disp_v != q.disp_v)
    begin
      d.tick_cnt = '0;
      d.pos      = '0;
      d.half     = 1'b0;
    end
    else if (d.disp_v && (|dc[CFG_LINE_LSB +: 6]) && q.ms_cnt == '0)
    begin
      if (q.tick_cnt + 20'h00001 >= limit)
      begin
        d.tick_cnt = '0;
        if (dc[CFG_TTYPE])
          d.half = ~q.half;
        else
          d.pos  = q.pos + 8'h01;
      end
      else
        d.tick_cnt = q.tick_cnt + 20'h00001;
    end

    // routed outputs follow the shown block
    d.onb   = d.disp_v && (dc[CFG_DST_LSB +: 2] == DST_ONB ||
                           dc[CFG_DST_LSB +: 2] == DST_BOTH);
    d.pan   = d.disp_v && (dc[CFG_DST_LSB +: 2] == DST_PANEL ||
                           dc[CFG_DST_LSB +: 2] == DST_BOTH);
    d.web   = d.disp_v && dc[CFG_WEB];
    d.lines = d.disp_v ? dc[CFG_LINE_LSB +: 6] : 6'h00;

    // write channel: address and data caught in either order
    if (s_axi_awvalid && q.awrdy)
    begin
      d.aw_v = 1'b1;
      d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wrdy)
    begin
      d.w_v = 1'b1;
      d.w_d = s_axi_wdata;
      d.w_s = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (q.aw_v && q.w_v && !q.bvalid)
    begin
      d.aw_v   = 1'b0;
      d.w_v    = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      widx     = (q.aw_a - ADDR_CFG0) >> 2;
      if (q.aw_a[11:2] == ADDR_CTRL[11:2])
      begin
        wword     = merge({q.tick_ms, 15'h0000, q.cs_use}, q.w_d, q.w_s);
        d.cs_use  = wword[CTRL_CSUSE];
        d.tick_ms = wword[CTRL_TICK_LSB +: 16];
      end
      else if (q.aw_a >= ADDR_CFG0 && widx < 12'(NB))
      begin
        wword = merge(32'(q.cfg[widx[IDX_W-1:0]]), q.w_d, q.w_s);
        d.cfg[widx[IDX_W-1:0]] = wword[CFG_W-1:0];
      end
      else
        d.bresp = RESP_SLVERR;
    end
    d.awrdy = !d.aw_v && !d.bvalid;
    d.wrdy  = !d.w_v && !d.bvalid;

    // read channel
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arrdy)
    begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      ridx     = (s_axi_araddr - ADDR_CFG0) >> 2;
      unique case (s_axi_araddr[11:2])
        ADDR_CTRL[11:2]:   d.rdata = {q.tick_ms, 15'h0000, q.cs_use};
        ADDR_STATUS[11:2]: d.rdata = {8'h00, q.pos, 6'h00, q.half, q.disp_v, 2'h0, q.disp};
        ADDR_ACT_LO[11:2]: d.rdata = q.active[31:0];
        ADDR_ACT_HI[11:2]: d.rdata = 32'(q.active[NB-1:32]);
        default:
        begin
          if (s_axi_araddr >= ADDR_CFG0 && ridx < 12'(NB))
            d.rdata = 32'(q.cfg[ridx[IDX_W-1:0]]);
          else
            d.rresp = RESP_SLVERR;
        end
      endcase
    end
    d.arrdy = !d.rvalid;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q         <= '0;
      q.cfg     <= {NB{CFG_RST}};
      q.tick_ms <= TICK_MS_RST;
    end
    else
      q <= d;
  end

  // outputs are flops of the state
  assign status_o              = q.active;
  assign disp_valid_o          = q.disp_v;
  assign disp_idx_o            = q.disp;
  assign onboard_screen_o      = q.onb;
  assign external_text_panel_o = q.pan;
  assign web_show_o            = q.web;
  assign line_scroll_enable_o  = q.lines;
  assign scroll_pos_o          = q.pos;
  assign line_half_o           = q.half;
  assign s_axi_awready         = q.awrdy;
  assign s_axi_wready          = q.wrdy;
  assign s_axi_bvalid          = q.bvalid;
  assign s_axi_bresp           = q.bresp;
  assign s_axi_arready         = q.arrdy;
  assign s_axi_rvalid          = q.rvalid;
  assign s_axi_rdata           = q.rdata;
  assign s_axi_rresp           = q.rresp;
endmodule // mtp_display

// *** verification/mtp_display_chk.sv ***
// Purpose: port-level checks for the message display block
// Assumes: one clock, reset active low
// Notes:   block settings are unseen here, so each check holds in every mode
`timescale 1ns/1ps
module mtp_display_chk
  import mtp_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  // program side
  input  wire logic [NB-1:0]    en_i,
  input  wire logic             run_i,
  input  wire logic [NB-1:0]    status_o,
  // display side
  input  wire logic             disp_valid_o,
  input  wire logic [IDX_W-1:0] disp_idx_o,
  input  wire logic             onboard_screen_o,
  input  wire logic             external_text_panel_o,
  input  wire logic             web_show_o,
  // register bus
  input  wire logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [1:0]       s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  input  wire logic             s_axi_arready,
  input  wire logic             s_axi_rvalid
);
  logic [NB-1:0] en_q;
  logic [NB-1:0] hold_q;
  logic [NB-1:0] rise;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // mirrors the edge detector so a level held through reset counts as a rise, as in the block
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      en_q   <= '0;
      hold_q <= '0;
    end
    else
    begin
      en_q   <= en_i;
      hold_q <= status_o & en_i & {NB{run_i}};
    end
  end
  assign rise = en_i & ~en_q;
  property p_start; run_i && |rise |=> (status_o & $past(rise)) == $past(rise); endproperty
  a_start: assert property (p_start) else $error("no activation on enable rise");
  property p_hold; |hold_q |-> (status_o & hold_q) == hold_q; endproperty
  a_hold: assert property (p_hold) else $error("status dropped while enabled");
  property p_drop; |($past(status_o) & ~status_o & $past(en_i)) |-> !$past(run_i); endproperty
  a_drop: assert property (p_drop) else $error("message removed with enable high");
  property p_run; !run_i |=> status_o == '0 && !disp_valid_o; endproperty
  a_run: assert property (p_run) else $error("message kept outside run state");
  property p_shown; disp_valid_o |-> disp_idx_o < NB && status_o[disp_idx_o]; endproperty
  a_shown: assert property (p_shown) else $error("shown block is not active");
  property p_route; !disp_valid_o |-> !(onboard_screen_o || external_text_panel_o || web_show_o);
  endproperty
  a_route: assert property (p_route) else $error("routing without a message");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
endmodule // mtp_display_chk

bind mtp_display mtp_display_chk mtp_display_chk_inst
(
  .ref_clk_i, .rstn_i, .en_i, .run_i, .status_o, .disp_valid_o, .disp_idx_o,
  .onboard_screen_o, .external_text_panel_o, .web_show_o, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// *** verification/mtp_panel_model.sv ***
// Purpose: operator key panel facing the display block
// Assumes: keys are clean levels, active high
// Notes:   lag stretches the operator's reaction to try slow presses
`timescale 1ns/1ps
module mtp_panel_model
  import mtp_pkg::*;
(
  // clock
  input  wire logic       ref_clk_i,
  // commands: ok, up, down and reaction lag
  input  wire logic [2:0] press_i,
  input  wire logic [3:0] lag_i,
  // key pins
  output logic      [2:0] key_o
);
  logic [2:0] sel_q = 3'h0;
  logic [4:0] cnt_q = 5'h00;
  initial key_o = 3'h0;
  // held four cycles so the press outlasts the two-flop synchroniser
  always @(posedge ref_clk_i)
  begin
    if (press_i != 3'h0)
    begin
      sel_q <= press_i;
      cnt_q <= {1'b0, lag_i} + 5'h05;
    end
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
    key_o <= (cnt_q != 5'h00 && cnt_q < 5'h05) ? sel_q : 3'h0;
  end
endmodule // mtp_panel_model

// *** verification/testbench.sv ***
// Purpose: self-checking bench for the message display block
// Assumes: short millisecond count so scroll intervals stay brief
// Notes:   keys come from the panel model, settings over AXI4-Lite
`timescale 1ns/1ps
module testbench
  import mtp_pkg::*;
;
  localparam int MS = 10;
  typedef struct packed { logic [5:0] idx; logic [18:0] cfg; logic [8:0] exp; } mtp_row_s;
  localparam mtp_row_s ROWS [4] = '{{6'h00, 19'h00200, 9'h100}, {6'h07, 19'h00C00, 9'h0C0},
                                    {6'h31, 19'h3F600, 9'h1BF}, {6'h14, 19'h15000, 9'h015}};
  logic          ref_clk_i = 1'b0;
  logic          rstn_i = 1'b0;
  logic [NB-1:0] en_i = '0;
  logic          run_i = 1'b0;
  logic          charset_select_flag_i = 1'b0;
  wire logic     key_ok_i, key_up_i, key_down_i;
  logic [2:0]    press = 3'h0;
  logic [3:0]    lag = 4'h0;
  logic [NB-1:0] status_o;
  logic          disp_valid_o, onboard_screen_o, external_text_panel_o, web_show_o, line_half_o;
  logic [5:0]    disp_idx_o, line_scroll_enable_o;
  logic [7:0]    scroll_pos_o;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0]   s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]    s_axi_wstrb = 4'hF;
  logic [1:0]    s_axi_bresp, s_axi_rresp, r;
  wire logic [8:0] route = {onboard_screen_o, external_text_panel_o, web_show_o,
                            line_scroll_enable_o};
  int            num_errors = 0;
  int            comparisons = 0;
  int            n;

  mtp_display #(.MS_CYCLES(MS)) mtp_display_inst
  (
    .ref_clk_i, .rstn_i, .en_i, .run_i, .charset_select_flag_i, .status_o, .key_ok_i,
    .key_up_i, .key_down_i, .disp_valid_o, .disp_idx_o, .onboard_screen_o,
    .external_text_panel_o, .web_show_o, .line_scroll_enable_o, .scroll_pos_o, .line_half_o,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
  );
  mtp_panel_model mtp_panel_model_inst
  (
    .ref_clk_i, .press_i(press), .lag_i(lag), .key_o({key_down_i, key_up_i, key_ok_i})
  );

  always #20 ref_clk_i = ~ref_clk_i;

  task automatic conclude();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    num_errors++;
    conclude();
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tk(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask

  // address and data offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge ref_clk_i);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rs = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
    // one idle edge so a following call never re-raises bready in the same step
    tk(1);
    if (k == 40)
      give_up();
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge ref_clk_i);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    tk(1);
    if (k == 40)
      give_up();
  endtask

  task automatic push(input logic [2:0] k, input logic [3:0] l);
    lag <= l;
    press <= k;
    tk(1);
    press <= 3'h0;
    tk(20 + l);
  endtask

  // cycles between two changes of scroll position or line half
  task automatic span(input logic sel, output int c);
    logic v;
    int k;
    for (k = 0; k < 2; k++)
    begin
      v = sel ? line_half_o : scroll_pos_o[0];
      for (c = 0; c < 300 && v === (sel ? line_half_o : scroll_pos_o[0]); c++)
        @(posedge ref_clk_i);
      if (c == 300)
        give_up();
    end
  endtask

  initial
  begin
    tk(12);
    rstn_i <= 1'b1;
    tk(2);
    check(status_o, 64'h0);
    axr(ADDR_CTRL, d, r);
    check(d, {TICK_MS_RST, 16'h0000});
    axr(ADDR_CFG0 + 12'h0C4, d, r);
    check(d, {13'h0000, CFG_RST});
    axw(12'h010, 32'h1, r);
    check(r, RESP_SLVERR);
    axr(12'h010, d, r);
    check({d, r}, {32'h0, RESP_SLVERR});
    axw(ADDR_CTRL, 32'h0001_0000, r);
    check(r, RESP_OKAY);
    run_i <= 1'b1;
    foreach (ROWS[i])
    begin
      axw(ADDR_CFG0 + {4'h0, ROWS[i].idx, 2'h0}, {13'h0000, ROWS[i].cfg}, r);
      en_i[ROWS[i].idx] <= 1'b1;
      tk(2);
      check({disp_valid_o, disp_idx_o}, {1'b1, ROWS[i].idx});
      check(route, ROWS[i].exp);
      en_i <= '0;
      tk(2);
      check({status_o, disp_valid_o}, 64'h0);
    end
    axw(ADDR_CFG0 + 12'h004, 32'h0000_0205, r);
    axw(ADDR_CFG0 + 12'h008, 32'h0000_0205, r);
    axw(ADDR_CFG0 + 12'h00C, 32'h0000_027F, r);
    en_i[1] <= 1'b1;
    tk(2);
    en_i[2] <= 1'b1;
    tk(2);
    check(disp_idx_o, 6'h01);
    en_i[3] <= 1'b1;
    tk(2);
    check(disp_idx_o, 6'h03);
    en_i[3] <= 1'b0;
    tk(2);
    check(disp_idx_o, 6'h01);
    push(3'h2, 4'h9);
    check(disp_idx_o, 6'h02);
    push(3'h4, 4'h0);
    check(disp_idx_o, 6'h01);
    en_i <= '0;
    axw(ADDR_CFG0 + 12'h010, 32'h0000_0280, r);
    en_i[4] <= 1'b1;
    tk(2);
    push(3'h1, 4'h0);
    check(status_o[4], 1'b1);
    en_i[4] <= 1'b0;
    tk(3);
    check({status_o[4], disp_idx_o}, {1'b1, 6'h04});
    push(3'h1, 4'h5);
    check(status_o, 64'h0);
    axw(ADDR_CTRL, 32'h0001_0001, r);
    axw(ADDR_CFG0 + 12'h014, 32'h0004_0200, r);
    en_i[5] <= 1'b1;
    tk(2);
    check({status_o[5], disp_valid_o}, 2'h2);
    charset_select_flag_i <= 1'b1;
    tk(2);
    check({disp_valid_o, disp_idx_o}, {1'b1, 6'h05});
    tk(30);
    check(scroll_pos_o, 8'h00);
    axw(ADDR_CFG0 + 12'h014, 32'h0004_1200, r);
    span(1'b0, n);
    check(n, MS);
    axw(ADDR_CFG0 + 12'h014, 32'h0004_1300, r);
    span(1'b1, n);
    check(n, LL_MULT * MS);
    run_i <= 1'b0;
    tk(2);
    check({status_o, disp_valid_o}, 64'h0);
    en_i[6] <= 1'b1;
    tk(2);
    run_i <= 1'b1;
    tk(3);
    check(status_o, 64'h0);
    en_i <= '0;
    tk(2);
    en_i[6] <= 1'b1;
    tk(2);
    check(status_o[6], 1'b1);
    en_i <= '0;
    rstn_i <= 1'b0;
    tk(2);
    rstn_i <= 1'b1;
    tk(2);
    check(status_o, 64'h0);
    conclude();
  end
endmodule // testbench
